// *** include/cfgimg_consts.vh ***
`ifndef CFGIMG_CONSTS_VH
`define CFGIMG_CONSTS_VH
// image byte offsets
`define CFGIMG_OFS_MARK 9'h000
`define CFGIMG_OFS_ADDR0 9'h001
`define CFGIMG_OFS_ADDR5 9'h006
`define CFGIMG_OFS_WKEN_LO 9'h007
`define CFGIMG_OFS_WKEN_HI 9'h008
`define CFGIMG_OFS_WKPOL_LO 9'h00e
`define CFGIMG_OFS_WKPOL_HI 9'h00f
`define CFGIMG_OFS_FS_POLL 9'h010
`define CFGIMG_OFS_HS_POLL 9'h011
`define CFGIMG_OFS_FLAGS0 9'h013
`define CFGIMG_OFS_FLAGS3_END 9'h022
`define CFGIMG_OFS_LANG_LO 9'h023
`define CFGIMG_OFS_LANG_HI 9'h024
`define CFGIMG_OFS_STR_FIRST 9'h025
`define CFGIMG_OFS_STR_LAST 9'h02e
// programmed indicator value
`define CFGIMG_MARK_VALUE 8'ha5
// descriptor store size in bytes, last address
`define CFGIMG_STORE_LAST 9'h1ff
// defaults kept when the image is absent
`define CFGIMG_DEF_POLL 8'h01
`define CFGIMG_DEF_LANG 16'h0409
`endif

// *** hdl/cfgimg_byte_reader.v ***
`timescale 1ns/10ps
`include "cfgimg_consts.vh"
// serial memory byte fetcher: one request, one byte answer
module cfgimg_byte_reader (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // request side
    input wire req,
    input wire [8:0] req_addr,
    output wire busy,
    output reg done,
    output reg [7:0] rdata,
    // memory pins
    output reg mem_cs,
    output reg mem_sck,
    output reg mem_di,
    input wire mem_do
);
    // read opcode with start bit, 3 bits then 9 address bits
    localparam [2:0] CFGIMG_OP_READ = 3'b110;
    // two flops before the data pin is read
    reg do_s1;
    reg do_s2;
    reg [20:0] shreg; // outgoing command bits
    reg [5:0] cnt; // half clock phases remaining
    reg [1:0] div; // slows the serial clock
    reg active;
    assign busy = active | req;
    ////////////////////////////////////////////////////////////////
    // pin synchroniser
    always @(posedge sys_clk) begin
        do_s1 <= mem_do;
        do_s2 <= do_s1;
    end
    ////////////////////////////////////////////////////////////////
    // shift engine; 12 command bits then 8 data bits, 2 phases each
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            active <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            mem_cs <= 1'b0;
            mem_sck <= 1'b0;
            mem_di <= 1'b0;
            shreg <= 21'h00_0000;
            cnt <= 6'h00;
            div <= 2'h0;
        end else begin
            done <= 1'b0;
            div <= div + 2'h1;
            if (!active) begin
                // accept a new fetch only when idle
                if (req) begin
                    active <= 1'b1;
                    mem_cs <= 1'b1;
                    // start bit goes out now, a full phase before the first rise
                    mem_di <= CFGIMG_OP_READ[2];
                    shreg <= {CFGIMG_OP_READ[1:0], req_addr, 10'h000};
                    cnt <= 6'h28;
                    div <= 2'h0;
                end
            end else if (div == 2'h3) begin
                if (cnt == 6'h00) begin
                    // slow edge done; a generous tail wait avoids pin skew
                    active <= 1'b0;
                    mem_cs <= 1'b0;
                    mem_sck <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt - 6'h01;
                    if (!mem_sck) begin
                        // low phase done: raise the clock on a settled bit
                        mem_sck <= 1'b1;
                    end else begin
                        // high phase done: lower the clock and present the next
                        // bit, so data never moves on the memory's sampling edge;
                        // sample data after 12 bits
                        mem_sck <= 1'b0;
                        mem_di <= shreg[20];
                        shreg <= {shreg[19:0], 1'b0};
                        if (cnt <= 6'h10) begin
                            rdata <= {rdata[6:0], do_s2};
                        end
                    end
                end
            end
        end
    end
endmodule

// *** hdl/cfgimg_loader.v ***
`timescale 1ns/10ps
`include "cfgimg_consts.vh"
module cfgimg_loader (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // reset requests: system reset pulse and usb bus reset pulse
    input wire sys_load,
    input wire bus_reset_load,
    // serial memory pins
    output wire mem_cs,
    output wire mem_sck,
    output wire mem_di,
    input wire mem_do,
    // loading state
    output reg load_done,
    output reg image_valid,
    output wire usb_connect,
    // loaded settings
    output reg [47:0] station_addr,
    output reg [11:0] gpio_wake_enable_field,
    output reg [11:0] gpio_wake_polarity_field,
    output reg [7:0] fs_poll_interval,
    output reg [7:0] hs_poll_interval,
    output reg [127:0] cfg_flags,
    output reg lang_id_valid,
    output reg [15:0] lang_id,
    // string table: 5 entries of length and byte address
    output reg [39:0] str_len,
    output reg [49:0] str_byte_addr,
    // descriptor store read port
    input wire [8:0] store_addr,
    output reg [7:0] store_data
);
    // one-hot states
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_REQ = 5'b00010;
    localparam [4:0] ST_WAIT = 5'b00100;
    localparam [4:0] ST_NEXT = 5'b01000;
    localparam [4:0] ST_END = 5'b10000;
    reg [4:0] state;
    reg [8:0] addr; // image byte being fetched
    reg mac_only; // bus reset pass: stop after address bytes
    reg [7:0] store [0:511]; // descriptor store
    reg [7:0] pend_len; // string length held for its offset byte
    wire rd_done;
    wire [7:0] rd_data;
    wire [8:0] base_len;
    ////////////////////////////////////////////////////////////////
    // word offset to byte address, used for every string entry of nonzero length
    function [9:0] word_to_byte;
        input [7:0] word_ofs;
        begin
            word_to_byte = {1'b0, word_ofs, 1'b0};
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    // byte fetcher
    cfgimg_byte_reader u_reader (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .req(state == ST_REQ),
        .req_addr(addr),
        .busy(),
        .done(rd_done),
        .rdata(rd_data),
        .mem_cs(mem_cs),
        .mem_sck(mem_sck),
        .mem_di(mem_di),
        .mem_do(mem_do)
    );
    ////////////////////////////////////////////////////////////////
    // hold disconnect
    assign usb_connect = load_done;
    assign base_len = `CFGIMG_STORE_LAST;
    ////////////////////////////////////////////////////////////////
    // store read port, registered
    always @(posedge sys_clk) begin
        store_data <= store[store_addr];
    end
    ////////////////////////////////////////////////////////////////
    // store write: whole image copied, the object store block and
    // every variable-length item therefore land wherever they sit
    always @(posedge sys_clk) begin
        // no fixed block size
        // the indicator byte is judged in the cycle it arrives, before
        // image_valid can follow it, so it is qualified by its own value
        if (state == ST_WAIT && rd_done && !mac_only &&
            ((addr == `CFGIMG_OFS_MARK) ? (rd_data == `CFGIMG_MARK_VALUE) : image_valid)) begin
            store[addr] <= rd_data;
        end
    end
    ////////////////////////////////////////////////////////////////
    // load sequencer and field capture
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            addr <= 9'h000;
            mac_only <= 1'b0;
            load_done <= 1'b0;
            image_valid <= 1'b0;
            station_addr <= 48'h0000_0000_0000;
            gpio_wake_enable_field <= 12'h000;
            gpio_wake_polarity_field <= 12'h000;
            fs_poll_interval <= `CFGIMG_DEF_POLL;
            hs_poll_interval <= `CFGIMG_DEF_POLL;
            cfg_flags <= 128'h0;
            lang_id_valid <= 1'b0;
            lang_id <= `CFGIMG_DEF_LANG;
            str_len <= 40'h00_0000_0000;
            str_byte_addr <= 50'h0;
            pend_len <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    // system reset wins over a bus reset arriving together
                    if (sys_load) begin
                        mac_only <= 1'b0;
                        load_done <= 1'b0;
                        // a full load starts from the defaults, so a blank image
                        // after a programmed one leaves no stale settings behind
                        image_valid <= 1'b0;
                        station_addr <= 48'h0000_0000_0000;
                        gpio_wake_enable_field <= 12'h000;
                        gpio_wake_polarity_field <= 12'h000;
                        fs_poll_interval <= `CFGIMG_DEF_POLL;
                        hs_poll_interval <= `CFGIMG_DEF_POLL;
                        cfg_flags <= 128'h0;
                        lang_id_valid <= 1'b0;
                        lang_id <= `CFGIMG_DEF_LANG;
                        str_len <= 40'h00_0000_0000;
                        str_byte_addr <= 50'h0;
                        addr <= `CFGIMG_OFS_MARK;
                        state <= ST_REQ;
                    end else if (bus_reset_load && image_valid) begin
                        mac_only <= 1'b1;
                        addr <= `CFGIMG_OFS_ADDR0;
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (rd_done) begin
                        state <= ST_NEXT;
                        if (addr == `CFGIMG_OFS_MARK) begin
                            image_valid <= (rd_data == `CFGIMG_MARK_VALUE);
                            if (rd_data != `CFGIMG_MARK_VALUE) begin
                                state <= ST_END;
                            end
                        end else if (addr <= `CFGIMG_OFS_ADDR5) begin
                            station_addr[(addr - 9'h001) * 8 +: 8] <= rd_data;
                        end else if (!mac_only) begin
                            case (addr)
                                `CFGIMG_OFS_WKEN_LO: gpio_wake_enable_field[7:0] <= rd_data;
                                `CFGIMG_OFS_WKEN_HI: gpio_wake_enable_field[11:8] <= rd_data[3:0];
                                `CFGIMG_OFS_WKPOL_LO: gpio_wake_polarity_field[7:0] <= rd_data;
                                `CFGIMG_OFS_WKPOL_HI: begin
                                    gpio_wake_polarity_field[11:8] <= rd_data[3:0];
                                end
                                `CFGIMG_OFS_FS_POLL: fs_poll_interval <= rd_data;
                                `CFGIMG_OFS_HS_POLL: hs_poll_interval <= rd_data;
                                `CFGIMG_OFS_LANG_LO: lang_id[7:0] <= rd_data;
                                `CFGIMG_OFS_LANG_HI: lang_id[15:8] <= rd_data;
                                default: begin
                                    if (addr >= `CFGIMG_OFS_FLAGS0 &&
                                        addr <= `CFGIMG_OFS_FLAGS3_END) begin
                                        cfg_flags[(addr - `CFGIMG_OFS_FLAGS0) * 8 +: 8] <= rd_data;
                                    end else if (addr >= `CFGIMG_OFS_STR_FIRST &&
                                                 addr <= `CFGIMG_OFS_STR_LAST) begin
                                        if (addr[0]) begin
                                            pend_len <= rd_data;
                                        end else begin
                                            str_len[((addr - 9'h026) >> 1) * 8 +: 8] <= pend_len;
                                            str_byte_addr[((addr - 9'h026) >> 1) * 10 +: 10]
                                                <= (pend_len != 8'h00) ?
                                                word_to_byte(rd_data) : 10'h000;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                end
                ST_NEXT: begin
                    // a bus reset pass stops after the last address octet
                    if ((mac_only && addr == `CFGIMG_OFS_ADDR5) || addr == base_len) begin
                        state <= ST_END;
                    end else begin
                        addr <= addr + 9'h001;
                        state <= ST_REQ;
                    end
                end
                ST_END: begin
                    // language only when some string exists
                    if (!mac_only) begin
                        lang_id_valid <= image_valid && (str_len != 40'h00_0000_0000);
                    end
                    load_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** dv/cfgimg_loader_sva.sv ***
`timescale 1ns/10ps
`include "cfgimg_consts.vh"
////////////////////////////////////////////////////////////
// watches the loader's ports; all in the core clock domain
module cfgimg_loader_sva (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // load requests
    input wire sys_load,
    input wire bus_reset_load,
    // memory select
    input wire mem_cs,
    // loading state
    input wire load_done,
    input wire image_valid,
    input wire usb_connect,
    // loaded settings
    input wire [11:0] gpio_wake_enable_field,
    input wire [7:0] fs_poll_interval,
    input wire [127:0] cfg_flags,
    input wire lang_id_valid,
    input wire [15:0] lang_id,
    input wire [39:0] str_len,
    input wire [49:0] str_byte_addr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_connect_gate: assert property (usb_connect == load_done)
        else $error("usb connect not tied to load done");
    a_reload_keeps_done: assert property (
        load_done && bus_reset_load && !sys_load |=> load_done)
        else $error("bus reload dropped load done");
    a_reload_keeps_rest: assert property (
        load_done && !sys_load |=> $stable(cfg_flags) && $stable(gpio_wake_enable_field)
        && $stable(fs_poll_interval)) else $error("setting changed outside a full load");
    a_no_lang_blank: assert property (
        load_done && !image_valid |-> !lang_id_valid) else $error("language id on blank image");
    a_blank_defaults: assert property (
        load_done && !image_valid |-> fs_poll_interval == `CFGIMG_DEF_POLL
        && lang_id == `CFGIMG_DEF_LANG) else $error("defaults lost on blank image");
    a_word_even: assert property (
        load_done |-> !str_byte_addr[0] && !str_byte_addr[10] && !str_byte_addr[20]
        && !str_byte_addr[30] && !str_byte_addr[40]) else $error("string address odd");
    a_absent_product: assert property (
        load_done && str_len[15:8] == 8'h00 |-> str_byte_addr[19:10] == 10'h000)
        else $error("absent product string has address");
    a_absent_config: assert property (
        load_done && str_len[31:24] == 8'h00 |-> str_byte_addr[39:30] == 10'h000)
        else $error("absent configuration string has address");
    a_blank_idle: assert property (
        load_done && !image_valid && !sys_load && !$past(sys_load) |=> !mem_cs)
        else $error("memory selected after blank image");
endmodule
bind cfgimg_loader cfgimg_loader_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
    .sys_load(sys_load), .bus_reset_load(bus_reset_load), .mem_cs(mem_cs),
    .load_done(load_done), .image_valid(image_valid), .usb_connect(usb_connect),
    .gpio_wake_enable_field(gpio_wake_enable_field), .fs_poll_interval(fs_poll_interval),
    .cfg_flags(cfg_flags), .lang_id_valid(lang_id_valid), .lang_id(lang_id),
    .str_len(str_len), .str_byte_addr(str_byte_addr));

// *** dv/cfgimg_mem_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// serial configuration memory; answers read commands, other opcodes with inverted data
module cfgimg_mem_model (
    // memory pins
    input wire mem_cs,
    input wire mem_sck,
    input wire mem_di,
    output reg mem_do
);
    reg [7:0] mem [0:511]; // image, filled by the bench
    reg [11:0] cmd; // start bit, opcode, address
    reg [7:0] shf; // byte being shifted out
    integer cnt; // rising clock edges since select
    initial begin
        mem_do = 1'b0;
        cnt = 0;
    end
    // a released line never keeps its last value
    always @(negedge mem_cs) begin
        mem_do <= ~mem_do;
    end
    always @(posedge mem_cs) begin
        cnt = 0;
    end
    always @(posedge mem_sck) begin
        if (mem_cs) begin
            cnt = cnt + 1;
            if (cnt <= 12) begin
                cmd = {cmd[10:0], mem_di};
            end
            // a wrong opcode reads back garbage
            if (cnt == 12) begin
                shf = (cmd[11:9] == 3'h6) ? mem[cmd[8:0]] : ~mem[cmd[8:0]];
            end
            // data follows the last address bit, one bit per rising edge
            if (cnt >= 13 && cnt <= 20) begin
                mem_do <= shf[7];
                shf = {shf[6:0], 1'h0};
            end else if (cnt > 20) begin
                mem_do <= ~mem_do;
            end
        end
    end
endmodule

// *** dv/cfgimg_loader_test.sv ***
`timescale 1ns/10ps
`include "cfgimg_consts.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module cfgimg_loader_test;
    reg sys_clk, rst_n, sys_load, bus_reset_load; // driven inputs
    reg [8:0] store_addr;
    wire mem_cs, mem_sck, mem_di, mem_do, load_done, image_valid, usb_connect, lang_id_valid;
    wire [47:0] station_addr;
    wire [11:0] gpio_wake_enable_field, gpio_wake_polarity_field;
    wire [7:0] fs_poll_interval, hs_poll_interval, store_data;
    wire [127:0] cfg_flags;
    wire [15:0] lang_id;
    wire [39:0] str_len;
    wire [49:0] str_byte_addr;
    integer errors, checked, cycles, i;
    reg [127:0] ef; // expected flags
    reg [47:0] ea; // expected station address
    reg [7:0] ln; // string length
    reg [11:0] ex; // expected wake field
    reg [9:0] ew; // expected string byte address
    cfgimg_loader dut (.sys_clk(sys_clk), .rst_n(rst_n), .sys_load(sys_load),
        .bus_reset_load(bus_reset_load), .mem_cs(mem_cs), .mem_sck(mem_sck), .mem_di(mem_di),
        .mem_do(mem_do), .load_done(load_done), .image_valid(image_valid),
        .usb_connect(usb_connect), .station_addr(station_addr),
        .gpio_wake_enable_field(gpio_wake_enable_field),
        .gpio_wake_polarity_field(gpio_wake_polarity_field),
        .fs_poll_interval(fs_poll_interval), .hs_poll_interval(hs_poll_interval),
        .cfg_flags(cfg_flags), .lang_id_valid(lang_id_valid), .lang_id(lang_id),
        .str_len(str_len), .str_byte_addr(str_byte_addr), .store_addr(store_addr),
        .store_data(store_data));
    cfgimg_mem_model mem_model (.mem_cs(mem_cs), .mem_sck(mem_sck), .mem_di(mem_di),
        .mem_do(mem_do));
    ////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a full load takes about 86k cycles, the whole run about 87k;
    // this cuts a hang short
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 95000) begin
            errors++;
            conclude;
        end
    end
    task step(input integer n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task full_load;
        sys_load = 1'h1;
        step(1);
        sys_load = 1'h0;
        step(3);
        `CHK("connect while loading", 1'h0, usb_connect)
        while (!load_done) step(1);
    endtask
    ////////////////////////////////////////////////////////////
    // blank image keeps defaults and refuses a bus reload
    task test_blank;
        mem_model.mem[0] = 8'h00;
        full_load;
        `CHK("image_valid", 1'h0, image_valid)
        `CHK("lang_id_valid", 1'h0, lang_id_valid)
        `CHK("fs_poll default", `CFGIMG_DEF_POLL, fs_poll_interval)
        bus_reset_load = 1'h1;
        step(1);
        bus_reset_load = 1'h0;
        ln = 8'h00;
        for (i = 0; i < 300; i++) begin
            step(1);
            if (mem_cs !== 1'h0) ln = 8'h01;
        end
        `CHK("refused reload", 8'h00, ln)
    endtask
    // programmed image fills every field and the store
    task test_valid;
        mem_model.mem[0] = `CFGIMG_MARK_VALUE;
        full_load;
        for (i = 1; i <= 6; i++) ea[8*(i-1)+:8] = mem_model.mem[i];
        for (i = 19; i <= 34; i++) ef[8*(i-19)+:8] = mem_model.mem[i];
        `CHK("station_addr", ea, station_addr)
        ex = {mem_model.mem[8][3:0], mem_model.mem[7]};
        `CHK("wake enable", ex, gpio_wake_enable_field)
        ex = {mem_model.mem[15][3:0], mem_model.mem[14]};
        `CHK("wake polarity", ex, gpio_wake_polarity_field)
        `CHK("fs poll", mem_model.mem[16], fs_poll_interval)
        `CHK("hs poll", mem_model.mem[17], hs_poll_interval)
        `CHK("cfg_flags", ef, cfg_flags)
        `CHK("lang_id", {mem_model.mem[36], mem_model.mem[35]}, lang_id)
        `CHK("lang_id_valid", 1'h1, lang_id_valid)
        for (i = 0; i < 5; i++) begin
            ln = mem_model.mem[37+2*i];
            `CHK("str_len", ln, str_len[8*i+:8])
            ew = (ln == 8'h00) ? 10'h000 : {mem_model.mem[38+2*i], 1'h0};
            `CHK("str addr", ew, str_byte_addr[10*i+:10])
        end
        for (i = 0; i < 3; i++) begin
            store_addr = 9'h0ff * i;
            step(2);
            `CHK("store", mem_model.mem[255*i], store_data)
        end
    endtask
    // bus reset reloads the address and nothing else
    task test_bus_reset;
        for (i = 1; i <= 6; i++) mem_model.mem[i] = ~mem_model.mem[i];
        mem_model.mem[7] = ~mem_model.mem[7];
        mem_model.mem[16] = 8'h22;
        bus_reset_load = 1'h1;
        step(1);
        bus_reset_load = 1'h0;
        for (i = 0; i < 3000 && station_addr !== ~ea; i++) step(1);
        `CHK("reloaded address", ~ea, station_addr)
        ex = {mem_model.mem[8][3:0], ~mem_model.mem[7]};
        `CHK("wake enable kept", ex, gpio_wake_enable_field)
        `CHK("fs poll kept", 8'h04, fs_poll_interval)
        `CHK("load_done kept", 1'h1, load_done)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checked = 0;
        cycles = 0;
        rst_n = 1'h0;
        sys_load = 1'h0;
        bus_reset_load = 1'h0;
        store_addr = 9'h000;
        for (i = 0; i < 512; i++) mem_model.mem[i] = i[7:0] ^ 8'h5a;
        mem_model.mem[8] = 8'h0a;
        mem_model.mem[15] = 8'h05;
        mem_model.mem[18] = 8'h00;
        mem_model.mem[16] = 8'h04;
        mem_model.mem[17] = 8'h08;
        mem_model.mem[35] = 8'h07;
        mem_model.mem[36] = 8'h04;
        mem_model.mem[38] = 8'h40;
        mem_model.mem[39] = 8'h00;
        mem_model.mem[41] = 8'h0a;
        mem_model.mem[42] = 8'hff;
        mem_model.mem[43] = 8'h00;
        mem_model.mem[45] = 8'h08;
        mem_model.mem[46] = 8'h20;
        mem_model.mem[53] = 8'h12;
        mem_model.mem[55] = 8'h12;
        // product string absent; its offset byte 40 still holds 72h, byte 54 holds 40h
        mem_model.mem[54] = 8'h40;
        mem_model.mem[143] = 8'h00;
        step(20);
        rst_n = 1'h1;
        test_blank;
        test_valid;
        test_bus_reset;
        conclude;
    end
endmodule
